// *** sfw_pkg.sv ***
// Purpose: Shared constants and types for the serial flash command sequencer.
// Assumes: pclk at 100 MHz; pins are asynchronous and synchronised in the sequencer.
// Notes: Register map, opcodes, phase lengths and timing counts live here.
`default_nettype none

package sfw_pkg;
    localparam logic [7:0] OP_WORD_READ = 8'he7;
    localparam logic [7:0] OP_SET_WRAP = 8'h77;
    localparam logic [7:0] OP_ID_SINGLE = 8'h90;
    localparam logic [7:0] OP_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_ID_QUAD = 8'h94;
    localparam logic [7:0] OP_ID_THREE = 8'h9f;
    localparam logic [7:0] OP_UNIQUE = 8'h4b;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE = 8'hab;
    localparam logic [7:0] OP_MODE_RESET = 8'hff;

    localparam logic [1:0] MODE_KEEP = 2'h2;
    localparam int MODE_LSB = 4;
    localparam int WRAP_FIELD_LSB = 4;
    localparam logic [2:0] WRAP_RESET = 3'h1;
    localparam int WB_DISABLE = 0;
    localparam int WB_LEN_LSB = 1;
    localparam logic [7:0] WRAP_MIN_LEN = 8'h08;
    localparam logic [7:0] FILL_BYTE = 8'h00;

    localparam logic [5:0] CLK_OPC = 6'h08;
    localparam logic [5:0] CLK_ADDR_X1 = 6'h18;
    localparam logic [5:0] CLK_ADDR_X2 = 6'h0c;
    localparam logic [5:0] CLK_ADDR_X4 = 6'h06;
    localparam logic [5:0] CLK_MODE_X4 = 6'h02;
    localparam logic [5:0] CLK_DUMMY_WORD = 6'h02;
    localparam logic [5:0] CLK_DUMMY_QID = 6'h04;
    localparam logic [5:0] CLK_DUMMY_UID = 6'h20;
    localparam logic [5:0] CLK_DUMMY_WRAP = 6'h18;
    localparam logic [5:0] CLK_WRAP_BYTE = 6'h08;

    localparam logic [2:0] LANES_X1 = 3'h1;
    localparam logic [2:0] LANES_X2 = 3'h2;
    localparam logic [2:0] LANES_X4 = 3'h4;
    localparam logic [3:0] OE_N_OFF = 4'hf;
    localparam logic [3:0] OE_N_X1 = 4'hd;
    localparam logic [3:0] OE_N_X2 = 4'hc;
    localparam logic [3:0] OE_N_X4 = 4'h0;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ID = 12'h008;
    localparam logic [11:0] REG_UID_LO = 12'h00c;
    localparam logic [11:0] REG_UID_HI = 12'h010;
    localparam logic [11:0] REG_MEM_PTR = 12'h014;
    localparam logic [11:0] REG_MEM_DATA = 12'h018;
    localparam int CTRL_QE_BIT = 9;
    localparam int CTRL_BUSY_BIT = 0;
    localparam int ST_SLEEP_BIT = 0;
    localparam int ST_PM_BIT = 1;
    localparam int ST_CONT_BIT = 2;
    localparam int ST_WRAP_LSB = 4;
    localparam int ID_MANUF_LSB = 0;
    localparam int ID_DEV_LSB = 8;
    localparam int ID_TYPE_LSB = 16;
    localparam int ID_CAP_LSB = 24;

    localparam int MEM_AW = 8;
    localparam int MEM_DW = 8;

    localparam int CLK_MHZ = 100;
    localparam int NS_PER_US = 1000;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int WAKE_NS = 3000;
    localparam logic [11:0] SLEEP_ENTRY_CYC = 12'(SLEEP_ENTRY_NS * CLK_MHZ / NS_PER_US);
    localparam logic [11:0] WAKE_CYC = 12'(WAKE_NS * CLK_MHZ / NS_PER_US);

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
    } sfw_pins_t;
    localparam sfw_pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

    typedef enum logic [3:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_WRAPB, ST_DATA, ST_ARMED, ST_IGNORE
    } sfw_state_t;
endpackage : sfw_pkg

`default_nettype wire

// *** sfw_mem.sv ***
// Purpose: Byte array image read by the sequencer, loaded over the register port.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data come out of a register one cycle after the address.
`default_nettype none

module sfw_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [sfw_pkg::MEM_AW-1:0] waddr,
    input wire logic [sfw_pkg::MEM_DW-1:0] wdata,
    // Read port
    input wire logic [sfw_pkg::MEM_AW-1:0] raddr,
    output logic [sfw_pkg::MEM_DW-1:0] rdata
);
    logic [sfw_pkg::MEM_DW-1:0] cells [2**sfw_pkg::MEM_AW];

    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= cells[raddr];
        end
    end
endmodule : sfw_mem

`default_nettype wire

// *** sfw_seq.sv ***
// Purpose: Command sequencer of a serial NOR flash: word read, wrap, IDs, sleep.
// Assumes: sclk, cs_n and data lines are asynchronous to pclk; sclk well below pclk/4.
// Notes: The byte array holds 256 bytes, mirrored into every page of the address space.
`default_nettype none

module sfw_seq #(
    // Identification values; these defaults are arbitrary.
    parameter logic [31:0] ID_RESET = 32'h11223344,
    parameter logic [63:0] UID_RESET = 64'h0123456789abcdef
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial flash pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] data_in,
    output logic [3:0] data_out,
    output logic [3:0] data_oe_n
);
    sfw_pkg::sfw_pins_t pin_raw, pin_meta, pin_sync, pin_last;
    sfw_pkg::sfw_state_t state, op_next, ph_next;
    logic [7:0] op;
    logic [5:0] cnt, byte_idx;
    logic [31:0] sh;
    logic [23:0] rd_addr;
    logic [2:0] bitpos, wrap_bits;
    logic [7:0] out_sr;
    logic cont, deep_sleep, pm_busy, pm_to_sleep;
    logic [11:0] pm_cnt;
    logic quad_io_enable_bit, busy;
    logic [31:0] id_reg;
    logic [63:0] uid_reg;
    logic [7:0] mem_ptr, mem_rdata;
    logic [31:0] status_word, rd_mux;

    assign pin_raw = '{cs_n: cs_n, sclk: sclk, io: data_in};

    // Only pin_sync and pin_last are looked at; pin_meta may be metastable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= sfw_pkg::PINS_IDLE;
            pin_sync <= sfw_pkg::PINS_IDLE;
            pin_last <= sfw_pkg::PINS_IDLE;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    wire cs_rise = pin_sync.cs_n & ~pin_last.cs_n;
    wire cs_fall = ~pin_sync.cs_n & pin_last.cs_n;
    wire cs_edge = cs_rise | cs_fall;
    wire sel_on = ~pin_sync.cs_n & ~cs_edge;
    wire clk_rise = sel_on & pin_sync.sclk & ~pin_last.sclk;
    wire clk_fall = sel_on & ~pin_sync.sclk & pin_last.sclk;
    wire asleep = deep_sleep | pm_busy;

    // Lane widths follow the command; the opcode itself is always one line.
    wire [2:0] lanes_out = (op == sfw_pkg::OP_WORD_READ || op == sfw_pkg::OP_ID_QUAD)
        ? sfw_pkg::LANES_X4 : (op == sfw_pkg::OP_ID_DUAL) ? sfw_pkg::LANES_X2 : sfw_pkg::LANES_X1;
    wire [2:0] lanes_in = (state == sfw_pkg::ST_OPCODE) ? sfw_pkg::LANES_X1 : lanes_out;
    wire [3:0] oe_n_now = (lanes_out == sfw_pkg::LANES_X4) ? sfw_pkg::OE_N_X4
        : (lanes_out == sfw_pkg::LANES_X2) ? sfw_pkg::OE_N_X2 : sfw_pkg::OE_N_X1;

    wire [31:0] shift_in = (lanes_in == sfw_pkg::LANES_X4) ? {sh[27:0], pin_sync.io}
        : (lanes_in == sfw_pkg::LANES_X2) ? {sh[29:0], pin_sync.io[1:0]}
        : {sh[30:0], pin_sync.io[0]};
    wire [7:0] opc = shift_in[7:0];

    wire [5:0] addr_clks = (op == sfw_pkg::OP_ID_SINGLE) ? sfw_pkg::CLK_ADDR_X1
        : (op == sfw_pkg::OP_ID_DUAL) ? sfw_pkg::CLK_ADDR_X2 : sfw_pkg::CLK_ADDR_X4;
    wire [5:0] dummy_clks = (op == sfw_pkg::OP_WORD_READ) ? sfw_pkg::CLK_DUMMY_WORD
        : (op == sfw_pkg::OP_ID_QUAD) ? sfw_pkg::CLK_DUMMY_QID
        : (op == sfw_pkg::OP_UNIQUE) ? sfw_pkg::CLK_DUMMY_UID
        : sfw_pkg::CLK_DUMMY_WRAP;
    wire [5:0] phase_clks = (state == sfw_pkg::ST_ADDR) ? addr_clks
        : (state == sfw_pkg::ST_MODE) ? sfw_pkg::CLK_MODE_X4
        : (state == sfw_pkg::ST_DUMMY) ? dummy_clks
        : (state == sfw_pkg::ST_WRAPB) ? sfw_pkg::CLK_WRAP_BYTE : sfw_pkg::CLK_OPC;
    wire phase_end = clk_rise & (cnt == phase_clks - 6'h01);
    wire opc_end = phase_end & (state == sfw_pkg::ST_OPCODE);
    wire body_end = phase_end & (state inside {sfw_pkg::ST_ADDR, sfw_pkg::ST_MODE,
        sfw_pkg::ST_DUMMY, sfw_pkg::ST_WRAPB});

    always_comb begin
        op_next = sfw_pkg::ST_IGNORE;
        if (asleep) begin
            if (opc == sfw_pkg::OP_WAKE) begin
                op_next = sfw_pkg::ST_ARMED;
            end
        end else if (opc == sfw_pkg::OP_WORD_READ) begin
            if (quad_io_enable_bit) begin
                op_next = sfw_pkg::ST_ADDR;
            end
        end else if (opc inside {sfw_pkg::OP_ID_SINGLE, sfw_pkg::OP_ID_DUAL,
                sfw_pkg::OP_ID_QUAD}) begin
            op_next = sfw_pkg::ST_ADDR;
        end else if (opc == sfw_pkg::OP_ID_THREE) begin
            if (!busy) begin
                op_next = sfw_pkg::ST_DATA;
            end
        end else if (opc == sfw_pkg::OP_UNIQUE || opc == sfw_pkg::OP_SET_WRAP) begin
            op_next = sfw_pkg::ST_DUMMY;
        end else if (opc == sfw_pkg::OP_SLEEP) begin
            op_next = sfw_pkg::ST_ARMED;
        end
    end

    always_comb begin
        ph_next = sfw_pkg::ST_IGNORE;
        if (state == sfw_pkg::ST_ADDR) begin
            if (op == sfw_pkg::OP_WORD_READ) begin
                ph_next = sfw_pkg::ST_MODE;
            end else if (op == sfw_pkg::OP_ID_QUAD) begin
                ph_next = sfw_pkg::ST_DUMMY;
            end else begin
                ph_next = sfw_pkg::ST_DATA;
            end
        end else if (state == sfw_pkg::ST_MODE) begin
            ph_next = sfw_pkg::ST_DUMMY;
        end else if (state == sfw_pkg::ST_DUMMY) begin
            ph_next = (op == sfw_pkg::OP_SET_WRAP) ? sfw_pkg::ST_WRAPB : sfw_pkg::ST_DATA;
        end
    end

    // Wrap arithmetic: the section base stays, only the offset inside it counts.
    wire [7:0] wrap_mask = (sfw_pkg::WRAP_MIN_LEN << wrap_bits[sfw_pkg::WB_LEN_LSB +: 2])
        - 8'h01;
    wire [7:0] sect_base = rd_addr[7:0] & ~wrap_mask;
    wire [23:0] addr_inc = rd_addr + 24'h000001;
    wire [23:0] next_addr = wrap_bits[sfw_pkg::WB_DISABLE] ? addr_inc
        : {rd_addr[23:8], sect_base | (addr_inc[7:0] & wrap_mask)};
    wire byte_load = clk_fall & (state == sfw_pkg::ST_DATA) & (bitpos == 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sfw_pkg::ST_IDLE;
            op <= 8'h00;
            cnt <= 6'h00;
            sh <= 32'h00000000;
            rd_addr <= 24'h000000;
            cont <= 1'b0;
            wrap_bits <= sfw_pkg::WRAP_RESET;
        end else if (cs_rise) begin
            state <= sfw_pkg::ST_IDLE;
        end else if (cs_fall) begin
            cnt <= 6'h00;
            if (cont && !asleep) begin
                state <= sfw_pkg::ST_ADDR;
                op <= sfw_pkg::OP_WORD_READ;
            end else begin
                state <= sfw_pkg::ST_OPCODE;
            end
        end else if (clk_rise) begin
            sh <= shift_in;
            cnt <= phase_end ? 6'h00 : cnt + 6'h01;
            if (state == sfw_pkg::ST_ARMED) begin
                state <= sfw_pkg::ST_IGNORE;
            end else if (opc_end) begin
                op <= opc;
                state <= op_next;
                if (!asleep && opc == sfw_pkg::OP_MODE_RESET) begin
                    cont <= 1'b0;
                end
            end else if (body_end) begin
                state <= ph_next;
                if (state == sfw_pkg::ST_ADDR) begin
                    rd_addr <= shift_in[23:0];
                end
                if (state == sfw_pkg::ST_MODE) begin
                    cont <= (shift_in[sfw_pkg::MODE_LSB +: 2] == sfw_pkg::MODE_KEEP);
                end
                if (state == sfw_pkg::ST_WRAPB) begin
                    wrap_bits <= shift_in[sfw_pkg::WRAP_FIELD_LSB +: 3];
                end
            end
        end else if (byte_load && op == sfw_pkg::OP_WORD_READ) begin
            rd_addr <= next_addr;
        end
    end

    wire [7:0] manuf = id_reg[sfw_pkg::ID_MANUF_LSB +: 8];
    wire [7:0] dev = id_reg[sfw_pkg::ID_DEV_LSB +: 8];
    wire [7:0] three_byte = (byte_idx == 6'h00) ? manuf
        : (byte_idx == 6'h01) ? id_reg[sfw_pkg::ID_TYPE_LSB +: 8]
        : (byte_idx == 6'h02) ? id_reg[sfw_pkg::ID_CAP_LSB +: 8] : sfw_pkg::FILL_BYTE;
    wire [7:0] uid_byte = uid_reg[{~byte_idx[2:0], 3'h0} +: 8];
    wire [7:0] pair_byte = (rd_addr[0] ^ byte_idx[0]) ? dev : manuf;
    wire [7:0] sel_byte = (op == sfw_pkg::OP_WORD_READ) ? mem_rdata
        : (op == sfw_pkg::OP_ID_THREE) ? three_byte
        : (op == sfw_pkg::OP_UNIQUE) ? uid_byte : pair_byte;

    function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] n);
        lane_bits = (n == sfw_pkg::LANES_X4) ? b[7:4]
            : (n == sfw_pkg::LANES_X2) ? {2'h0, b[7:6]} : {2'h0, b[7], 1'b0};
    endfunction : lane_bits

    // Data change on the falling serial clock so the host samples on the rising one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bitpos <= 3'h0;
            byte_idx <= 6'h00;
            out_sr <= 8'h00;
            data_out <= 4'h0;
            data_oe_n <= sfw_pkg::OE_N_OFF;
        end else if (cs_edge) begin
            bitpos <= 3'h0;
            byte_idx <= 6'h00;
            data_oe_n <= sfw_pkg::OE_N_OFF;
        end else if (clk_fall && state == sfw_pkg::ST_DATA) begin
            bitpos <= bitpos + lanes_out;
            data_oe_n <= oe_n_now;
            if (bitpos == 3'h0) begin
                data_out <= lane_bits(sel_byte, lanes_out);
                out_sr <= sel_byte << lanes_out;
                byte_idx <= byte_idx + 6'h01;
            end else begin
                data_out <= lane_bits(out_sr, lanes_out);
                out_sr <= out_sr << lanes_out;
            end
        end
    end

    // A valid sleep or release only counts when select rises in the armed state.
    wire armed_ok = cs_rise & (state == sfw_pkg::ST_ARMED);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep <= 1'b0;
            pm_busy <= 1'b0;
            pm_to_sleep <= 1'b0;
            pm_cnt <= 12'h000;
        end else if (armed_ok) begin
            pm_busy <= 1'b1;
            pm_to_sleep <= (op == sfw_pkg::OP_SLEEP);
            pm_cnt <= (op == sfw_pkg::OP_SLEEP) ? sfw_pkg::SLEEP_ENTRY_CYC - 12'h001
                : sfw_pkg::WAKE_CYC - 12'h001;
        end else if (pm_busy) begin
            if (pm_cnt == 12'h000) begin
                pm_busy <= 1'b0;
                deep_sleep <= pm_to_sleep;
            end else begin
                pm_cnt <= pm_cnt - 12'h001;
            end
        end
    end

    wire setup = psel & ~penable;
    wire wr_go = psel & penable & pwrite & pready;
    wire hit_ctrl = (paddr == sfw_pkg::REG_CTRL);
    wire hit_stat = (paddr == sfw_pkg::REG_STATUS);
    wire hit_id = (paddr == sfw_pkg::REG_ID);
    wire hit_ulo = (paddr == sfw_pkg::REG_UID_LO);
    wire hit_uhi = (paddr == sfw_pkg::REG_UID_HI);
    wire hit_mptr = (paddr == sfw_pkg::REG_MEM_PTR);
    wire hit_mdat = (paddr == sfw_pkg::REG_MEM_DATA);
    wire hit = hit_ctrl | hit_stat | hit_id | hit_ulo | hit_uhi | hit_mptr | hit_mdat;
    wire mem_we = wr_go & hit_mdat;

    always_comb begin
        status_word = 32'h00000000;
        status_word[sfw_pkg::ST_SLEEP_BIT] = deep_sleep;
        status_word[sfw_pkg::ST_PM_BIT] = pm_busy;
        status_word[sfw_pkg::ST_CONT_BIT] = cont;
        status_word[sfw_pkg::ST_WRAP_LSB +: 3] = wrap_bits;
        rd_mux = 32'h00000000;
        if (hit_ctrl) begin
            rd_mux[sfw_pkg::CTRL_QE_BIT] = quad_io_enable_bit;
            rd_mux[sfw_pkg::CTRL_BUSY_BIT] = busy;
        end else if (hit_stat) begin
            rd_mux = status_word;
        end else if (hit_id) begin
            rd_mux = id_reg;
        end else if (hit_ulo) begin
            rd_mux = uid_reg[31:0];
        end else if (hit_uhi) begin
            rd_mux = uid_reg[63:32];
        end else if (hit_mptr) begin
            rd_mux = {24'h000000, mem_ptr};
        end
    end

    // Zero-wait slave: the answer is registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            quad_io_enable_bit <= 1'b0;
            busy <= 1'b0;
            id_reg <= ID_RESET;
            uid_reg <= UID_RESET;
            mem_ptr <= 8'h00;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            if (setup) begin
                prdata <= rd_mux;
            end
            if (wr_go && hit_ctrl) begin
                quad_io_enable_bit <= pwdata[sfw_pkg::CTRL_QE_BIT];
                busy <= pwdata[sfw_pkg::CTRL_BUSY_BIT];
            end
            if (wr_go && hit_id) begin
                id_reg <= pwdata;
            end
            if (wr_go && hit_ulo) begin
                uid_reg[31:0] <= pwdata;
            end
            if (wr_go && hit_uhi) begin
                uid_reg[63:32] <= pwdata;
            end
            if (wr_go && hit_mptr) begin
                mem_ptr <= pwdata[7:0];
            end else if (mem_we) begin
                mem_ptr <= mem_ptr + 8'h01;
            end
        end
    end

    sfw_mem u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .we(mem_we),
        .waddr(mem_ptr),
        .wdata(pwdata[7:0]),
        .raddr(rd_addr[7:0]),
        .rdata(mem_rdata)
    );

    localparam int SLEEP_BOUND = sfw_pkg::SLEEP_ENTRY_CYC + 2;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_qe_gate: assert property (
        opc_end && !asleep && opc == sfw_pkg::OP_WORD_READ && !quad_io_enable_bit
        |=> state != sfw_pkg::ST_ADDR)
        else $error("word read accepted without quad enable");
    a_mode_keep: assert property (
        body_end && state == sfw_pkg::ST_MODE
        && shift_in[sfw_pkg::MODE_LSB +: 2] == sfw_pkg::MODE_KEEP |=> cont)
        else $error("continuous mode not armed by mode bits");
    a_cont_skip: assert property (
        cs_fall && cont && !asleep |=> state == sfw_pkg::ST_ADDR && op == sfw_pkg::OP_WORD_READ)
        else $error("continuous mode did not skip the opcode");
    a_mode_drop: assert property (
        body_end && state == sfw_pkg::ST_MODE
        && shift_in[sfw_pkg::MODE_LSB +: 2] != sfw_pkg::MODE_KEEP |=> !cont)
        else $error("continuous mode kept with wrong mode bits");
    a_deselect_idle: assert property (
        cs_rise |=> state == sfw_pkg::ST_IDLE && data_oe_n == sfw_pkg::OE_N_OFF)
        else $error("deselect did not return to standby");
    a_sleep_entry: assert property (
        armed_ok && op == sfw_pkg::OP_SLEEP |-> ##[1:SLEEP_BOUND] deep_sleep)
        else $error("sleep state not entered in time");
    a_asleep_ignore: assert property (
        opc_end && asleep && opc != sfw_pkg::OP_WAKE
        |=> state inside {sfw_pkg::ST_IGNORE, sfw_pkg::ST_IDLE})
        else $error("command decoded while asleep");
    a_addr_step: assert property (
        byte_load && op == sfw_pkg::OP_WORD_READ && wrap_bits[sfw_pkg::WB_DISABLE]
        |=> rd_addr == $past(rd_addr) + 24'h000001)
        else $error("read address did not advance by one");
    a_wrap_section: assert property (
        byte_load && op == sfw_pkg::OP_WORD_READ && !wrap_bits[sfw_pkg::WB_DISABLE]
        |=> sect_base == $past(sect_base))
        else $error("wrapped read left its section");
    a_busy_three_id: assert property (
        opc_end && !asleep && opc == sfw_pkg::OP_ID_THREE && busy
        |=> state != sfw_pkg::ST_DATA)
        else $error("three-byte id decoded while busy");
endmodule : sfw_seq

`default_nettype wire

// *** sfw_host_model.sv ***
// Purpose: Host controller model on the flash pins.
// Assumes: Mode 0, 160 ns serial clock; one, two or four lines after the opcode.
// Notes: Outside frames the clock rests low and the input line flips.
`default_nettype none
module sfw_host_model (
    // Flash pins
    input wire logic [3:0] data_out,
    output logic cs_n,
    output logic sclk,
    output logic [3:0] data_in,
    // Received byte and its toggle
    output logic [7:0] rx,
    output logic rx_t
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {cs_n, sclk, data_in, rx_t} = 7'h40;
    // With skip set the opcode byte is left out, as in continuous read mode.
    task automatic run(input logic [7:0] op, input logic [31:0] tx, input int nt, input int nr,
        input int ln = 1, input int nd = 0, input bit skip = 1'b0);
        int ob;
        int k;
        ob = skip ? 0 : 8;
        for (int i = 0; i < ob + nt + nd + nr * 8 / ln; i++) begin
            cs_n = 1'b0;
            k = i - ob;
            if (i < ob) data_in[0] = op[7 - i];
            else if (k < nt && ln == 4) data_in = tx[4 * (nt - 1 - k) +: 4];
            else if (k < nt && ln == 2) data_in = {2'h0, tx[2 * (nt - 1 - k) +: 2]};
            else if (k < nt) data_in[0] = tx[nt - 1 - k];
            #80 sclk = 1'b1;
            if (ln == 4) rx = {rx[3:0], data_out};
            else if (ln == 2) rx = {rx[5:0], data_out[1:0]};
            else rx = {rx[6:0], data_out[1]};
            if (k >= nt + nd && (k - nt - nd) % (8 / ln) == 8 / ln - 1) rx_t = ~rx_t;
            #80 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        data_in = ~data_in;
        #80;
    endtask : run
endmodule : sfw_host_model
`default_nettype wire

// *** sfw_seq_tb_top.sv ***
// Purpose: Self-checking bench for the flash command sequencer.
// Assumes: APB master here, host model on the flash pins.
// Notes: Expected results wait in queues until a watcher sees them.
`default_nettype none
module sfw_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cs_n, sclk, rx_t, quiet;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, id;
    logic [3:0] data_in, data_out, data_oe_n;
    logic [7:0] rx, spi_q[$];
    logic [7:0] mb[8];
    logic [32:0] apb_q[$];
    int bad_count, comparisons, cycles;
    int seed = 32'hb1df;
    sfw_seq #(.UID_RESET(64'h0f1e2d3c4b5a6978)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cs_n, .sclk, .data_in, .data_out, .data_oe_n);
    sfw_host_model host (.data_out, .cs_n, .sclk, .data_in, .rx, .rx_t);
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic summarize;
        if (apb_q.size() + spi_q.size() != 0 || cycles > 30000) bad_count++;
        if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] e,
        input logic [31:0] d = 32'h0);
        if (!w) apb_q.push_back(e);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b0;
    endtask : apb
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (psel && penable && pready && !pwrite) cmp({pslverr, prdata}, apb_q.pop_front());
        if (quiet) cmp({29'h0, data_oe_n}, 33'hf);
        if (cycles > 30000) summarize();
    end
    always @(posedge rx_t or negedge rx_t) if (cycles > 0) cmp(33'(rx), 33'(spi_q.pop_front()));
    initial begin
        {pclk, presetn, psel, penable, pwrite, quiet, paddr, pwdata} = 50'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 33'h10);
        apb(1'b0, 12'hffc, 33'h100000000);
        id = $random(seed);
        apb(1'b1, 12'h008, 33'h0, id);
        spi_q = '{id[7:0], id[23:16], id[31:24], id[15:8], id[7:0], 8'h0f, 8'h1e};
        host.run(8'h9f, 32'h0, 0, 3);
        host.run(8'h90, 32'h1, 24, 2);
        host.run(8'h4b, 32'h0, 32, 2);
        for (int w = 0; w < 8; w++) begin
            host.run(8'h77, 32'(w * 16), 32, 0);
            apb(1'b0, 12'h004, 33'(w * 16));
        end
        apb(1'b1, 12'h000, 33'h0, 32'h1);
        quiet = 1'b1;
        host.run(8'h9f, 32'h0, 24, 0);
        quiet = 1'b0;
        apb(1'b1, 12'h000, 33'h0, 32'h0);
        host.run(8'hb9, 32'h0, 1, 0);
        repeat (300) @(posedge pclk);
        apb(1'b0, 12'h004, 33'h70);
        host.run(8'hb9, 32'h0, 0, 0);
        repeat (300) @(posedge pclk);
        apb(1'b0, 12'h004, 33'h71);
        quiet = 1'b1;
        host.run(8'h9f, 32'h0, 24, 0);
        quiet = 1'b0;
        host.run(8'hab, 32'h0, 0, 0);
        repeat (300) @(posedge pclk);
        apb(1'b0, 12'h004, 33'h70);
        apb(1'b1, 12'h000, 33'h0, 32'h200);
        apb(1'b1, 12'h014, 33'h0, 32'h10);
        for (int j = 0; j < 8; j++) begin
            mb[j] = 8'($random(seed));
            apb(1'b1, 12'h018, 33'h0, 32'(mb[j]));
        end
        spi_q = '{mb[4], mb[5], mb[6], mb[6], mb[7], mb[6], mb[7], mb[0], mb[1],
            id[7:0], id[15:8], id[15:8], id[7:0]};
        host.run(8'he7, 32'h00001420, 8, 3, 4, 2);
        apb(1'b0, 12'h004, 33'h74);
        host.run(8'h00, 32'h00001600, 8, 2, 4, 2, 1'b1);
        apb(1'b0, 12'h004, 33'h70);
        host.run(8'h77, 32'h0, 32, 0);
        apb(1'b0, 12'h004, 33'h0);
        host.run(8'he7, 32'h00001620, 8, 4, 4, 2);
        host.run(8'h00, 32'hffffffff, 8, 0, 4, 0, 1'b1);
        apb(1'b0, 12'h004, 33'h0);
        host.run(8'h92, 32'h0, 12, 2, 2);
        host.run(8'h94, 32'h1, 6, 2, 4, 4);
        summarize();
    end
endmodule : sfw_seq_tb_top
`default_nettype wire
